// ---- rtl/smts_params.svh ----
// constants of the station mode and tributary setup interpreter
`ifndef SMTS_PARAMS_SVH
`define SMTS_PARAMS_SVH
`define SMTS_CMD_CONTROL 3'h1
`define SMTS_CMD_MODE 3'h2
`define SMTS_NSLOT 8
`define SMTS_SLOT_W 3
`define SMTS_CNT_W 16
`define SMTS_ROLE_P2P_LEG 2'h0
`define SMTS_ROLE_P2P 2'h1
`define SMTS_ROLE_CTRL 2'h2
`define SMTS_ROLE_TRIB 2'h3
`define SMTS_KEY_ESTABLISH 5'h01
`define SMTS_KEY_POLL 5'h02
`define SMTS_P2P_ADDR 8'h01
`define SMTS_POLL_IVL_RST 8'h04
`define SMTS_POLL_LVL_MAX 2'h3
`define SMTS_CNT_MSG_TX 3'h0
`define SMTS_CNT_MSG_RX 3'h1
`define SMTS_CNT_SEL_IVL 3'h2
`define SMTS_CNT_SEL_TMO 3'h3
`define SMTS_CNT_REPLY_TMO 3'h4
`define SMTS_CNT_DATA_ERR_OUT 3'h5
`define SMTS_CNT_DATA_ERR_IN 3'h6
`define SMTS_CNT_BUF_ERR 3'h7
`define SMTS_CLK_MHZ 25
`define SMTS_POLL_TICK_US 1000
`define SMTS_POLL_TICK_CYC (`SMTS_POLL_TICK_US * `SMTS_CLK_MHZ)
`endif

// ---- rtl/smts_pkg.sv ----
// types of the station mode and tributary setup interpreter
package smts_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_GRANT = 4'b0010,
        ST_EXEC = 4'b0100,
        ST_CLR = 4'b1000
    } smts_state_e;

    typedef logic [7:0] smts_addr_t;

    // index of lowest set bit; zero when none set
    function automatic logic [2:0] smts_first_one(input logic [7:0] vec);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (vec[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : smts_first_one
endpackage : smts_pkg

// ---- rtl/smts_slot_mem.sv ----
// counter memory of the tributary status slots, two registered read ports
`timescale 1ns/1ns
`include "smts_params.svh"
module smts_slot_mem (
    input wire logic clk, // controller clock
    input wire logic wr_en, // write strobe
    input wire logic [5:0] wr_addr, // slot and counter index
    input wire logic [15:0] wr_data, // value written
    input wire logic [5:0] rd_a_addr, // update port address
    output logic [15:0] rd_a_data, // update port data, registered
    input wire logic [5:0] rd_b_addr, // host port address
    output logic [15:0] rd_b_data // host port data, registered
);
    logic [15:0] mem [64];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_a_data <= mem[rd_a_addr];
        rd_b_data <= mem[rd_b_addr];
    end
endmodule : smts_slot_mem

// ---- rtl/smts_top.sv ----
// station mode definition and tributary control command interpreter
`timescale 1ns/1ns
`include "smts_params.svh"
module smts_top #(
    parameter int unsigned POLL_TICK_CYCLES = `SMTS_POLL_TICK_CYC // poll time base
) (
    input wire logic clk, // controller clock
    input wire logic arst_n, // asynchronous reset, active low
    input wire logic master_clear, // master clear pulse
    input wire logic run_ind, // diagnostics passed, running
    input wire logic [7:0] initialization_byte, // bit 3 is diagnostic mode
    input wire logic input_request, // host asks for the ports
    input wire logic grant_release, // host clears input grant flag
    input wire logic [7:0] command_select_byte, // command type in bits 2:0
    input wire logic [15:0] command_parameter_word, // low byte is parameter byte
    input wire logic [7:0] tributary_addr_byte, // tributary address of command
    input wire logic [2:0] mode_switch, // mode selection switches
    input wire logic mode_switch_en, // mode comes from switches
    input wire logic trib_switch_en, // tributary address from switches
    input wire logic [7:0] trib_switch_addr, // switch tributary address
    input wire logic evt_valid, // line engine event strobe
    input wire logic [2:0] evt_slot, // slot of the event
    input wire logic [2:0] evt_kind, // counter selected by event
    input wire logic [2:0] stat_slot, // host read slot
    input wire logic [2:0] stat_loc, // host read counter
    output logic [15:0] stat_data, // counter value, registered
    output logic input_grant_flag, // host owns the ports
    output logic cmd_done, // command accepted pulse
    output logic cmd_error, // command refused pulse
    output logic full_duplex, // line characteristic
    output logic [1:0] station_role, // station role code
    output logic role_locked, // role set by command
    output logic [7:0] slot_valid, // established slots
    output logic poll_strobe, // poll a tributary pulse
    output logic [2:0] poll_slot // slot to poll
);
    localparam int NS = `SMTS_NSLOT;

    smts_pkg::smts_state_e state_ff, nxt_state;
    logic grant_ff, done_ff, err_ff, dup_ff, lock_ff, ovr_ff;
    logic [1:0] role_ff;
    logic [2:0] sw_prev_ff;
    logic [7:0] sel_ff, taddr_ff;
    logic [15:0] parm_ff;
    logic [2:0] clr_slot_ff, clr_idx_ff;
    logic evt_pend_ff;
    logic [5:0] evt_addr_ff;
    logic [14:0] tick_cnt_ff;
    logic tick_ff, pstb_ff;
    logic [2:0] pslot_ff;

    // command decode
    wire is_mode = sel_ff[2:0] == `SMTS_CMD_MODE;
    wire is_ctl = sel_ff[2:0] == `SMTS_CMD_CONTROL;
    wire [2:0] mode_code = parm_ff[2:0];
    wire [1:0] cmd_role = mode_code[2:1];
    wire diag_mode = initialization_byte[3];
    wire sw_changed = mode_switch != sw_prev_ff;
    // switches own the mode unless a diagnostic override stands
    wire sw_owns = mode_switch_en && !ovr_ff;
    wire mode_ok = (!mode_switch_en || diag_mode)
                   && (!lock_ff || cmd_role == role_ff);
    wire key_form = parm_ff[7:5] == 3'h0;
    wire [4:0] ctl_key = parm_ff[4:0];
    wire is_est = key_form && ctl_key == `SMTS_KEY_ESTABLISH;
    wire is_poll = key_form && ctl_key == `SMTS_KEY_POLL;
    wire [7:0] est_addr = (trib_switch_en && taddr_ff != 8'h00)
                          ? trib_switch_addr : taddr_ff;
    wire is_p2p = !role_ff[1];
    wire is_ctrl_stn = role_ff == `SMTS_ROLE_CTRL;

    logic [7:0] slot_v, slot_hit, due_v;
    wire [2:0] free_idx = smts_pkg::smts_first_one(~slot_v);
    wire [2:0] hit_idx = smts_pkg::smts_first_one(slot_hit);
    wire any_free = slot_v != 8'hff;
    wire any_hit = slot_hit != 8'h00;
    // point to point keeps one slot at address one
    wire p2p_bad = is_p2p && (est_addr != `SMTS_P2P_ADDR
                   || (slot_v != 8'h00 && !any_hit));
    wire est_bad = est_addr == 8'h00 || p2p_bad || (!any_hit && !any_free);
    wire exec = state_ff == smts_pkg::ST_EXEC;
    wire mode_take = exec && is_mode && mode_ok;
    wire est_take = exec && is_ctl && is_est && !est_bad && !any_hit;
    wire poll_take = exec && is_ctl && is_poll && is_ctrl_stn && any_hit;
    wire cmd_ok = mode_take || (exec && is_ctl && is_est && !est_bad) || poll_take;
    wire mc_clear = master_clear;

    // handshake sequencing
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            smts_pkg::ST_IDLE: begin
                if (input_request && run_ind) begin
                    nxt_state = smts_pkg::ST_GRANT;
                end
            end
            smts_pkg::ST_GRANT: begin
                if (grant_release) begin
                    nxt_state = smts_pkg::ST_EXEC;
                end
            end
            smts_pkg::ST_EXEC: begin
                nxt_state = est_take ? smts_pkg::ST_CLR : smts_pkg::ST_IDLE;
            end
            smts_pkg::ST_CLR: begin
                if (clr_idx_ff == 3'h7) begin
                    nxt_state = smts_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = smts_pkg::ST_IDLE;
            end
        endcase
        if (mc_clear) begin
            nxt_state = smts_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= smts_pkg::ST_IDLE;
            grant_ff <= 1'b0;
            done_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            grant_ff <= nxt_state == smts_pkg::ST_GRANT;
            done_ff <= cmd_ok && !mc_clear;
            err_ff <= exec && !cmd_ok && !mc_clear;
        end
    end

    // ports sampled as the host hands them back
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_ff <= 8'h00;
            parm_ff <= 16'h0000;
            taddr_ff <= 8'h00;
        end else if (state_ff == smts_pkg::ST_GRANT && grant_release) begin
            sel_ff <= command_select_byte;
            parm_ff <= command_parameter_word;
            taddr_ff <= tributary_addr_byte;
        end
    end

    // station role and line characteristic
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            role_ff <= `SMTS_ROLE_P2P_LEG;
            dup_ff <= 1'b0;
            lock_ff <= 1'b0;
            ovr_ff <= 1'b0;
            sw_prev_ff <= 3'h0;
        end else begin
            sw_prev_ff <= mode_switch;
            if (mc_clear || (sw_changed && mode_switch_en)) begin
                lock_ff <= 1'b0;
                ovr_ff <= 1'b0;
            end else if (mode_take) begin
                lock_ff <= 1'b1;
                ovr_ff <= mode_switch_en;
            end
            // a clear never disturbs a switch role
            if (mode_take && !mc_clear) begin
                role_ff <= cmd_role;
                dup_ff <= mode_code[0];
            end else if (sw_owns || (mode_switch_en && (mc_clear || sw_changed))) begin
                role_ff <= mode_switch[2:1];
                dup_ff <= mode_switch[0];
            end
        end
    end

    // counters of a fresh slot are zeroed one word a cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clr_slot_ff <= 3'h0;
            clr_idx_ff <= 3'h0;
        end else if (est_take) begin
            clr_slot_ff <= free_idx;
            clr_idx_ff <= 3'h0;
        end else if (state_ff == smts_pkg::ST_CLR) begin
            clr_idx_ff <= clr_idx_ff + 3'h1;
        end
    end

    // counter update is read then write; events need a gap of one cycle
    wire evt_take = evt_valid && !evt_pend_ff && state_ff != smts_pkg::ST_CLR && !est_take
                    && slot_v[evt_slot];
    wire [15:0] cnt_rd;
    wire cnt_full = cnt_rd == 16'hffff;
    wire mem_we = state_ff == smts_pkg::ST_CLR || evt_pend_ff;
    wire [5:0] mem_wa = state_ff == smts_pkg::ST_CLR ? {clr_slot_ff, clr_idx_ff} : evt_addr_ff;
    // saturate so a busy line never wraps a count to zero
    wire [15:0] mem_wd = state_ff == smts_pkg::ST_CLR ? 16'h0000
                         : (cnt_full ? cnt_rd : cnt_rd + 16'h0001);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            evt_pend_ff <= 1'b0;
            evt_addr_ff <= 6'h00;
        end else begin
            evt_pend_ff <= evt_take;
            if (evt_take) begin
                evt_addr_ff <= {evt_slot, evt_kind};
            end
        end
    end

    smts_slot_mem u_mem (
        .clk(clk),
        .wr_en(mem_we),
        .wr_addr(mem_wa),
        .wr_data(mem_wd),
        .rd_a_addr({evt_slot, evt_kind}),
        .rd_a_data(cnt_rd),
        .rd_b_addr({stat_slot, stat_loc}),
        .rd_b_data(stat_data)
    );

    // poll time base
    wire tick_end = tick_cnt_ff == 15'(POLL_TICK_CYCLES - 1);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_ff <= 15'h0000;
            tick_ff <= 1'b0;
        end else begin
            tick_cnt_ff <= tick_end ? 15'h0000 : tick_cnt_ff + 15'h0001;
            tick_ff <= tick_end;
        end
    end

    wire poll_run = is_ctrl_stn && run_ind;
    wire evt_now = evt_take && state_ff != smts_pkg::ST_CLR;

    for (genvar i = 0; i < NS; i++) begin : g_slot
        logic v_ff, due_ff;
        logic [7:0] addr_ff, ivl_ff;
        logic [1:0] lvl_ff;
        logic [10:0] cnt_ff;
        wire served = pstb_ff && pslot_ff == 3'(i);
        wire mine = evt_now && evt_slot == 3'(i);
        wire expire = poll_run && v_ff && tick_ff && cnt_ff == 11'h000;
        // quieter tributaries are polled less often
        wire [10:0] reload = 11'({3'h0, ivl_ff} << lvl_ff);
        assign slot_v[i] = v_ff;
        assign slot_hit[i] = v_ff && addr_ff == est_addr;
        assign due_v[i] = due_ff;
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                v_ff <= 1'b0;
                addr_ff <= 8'h00;
                ivl_ff <= `SMTS_POLL_IVL_RST;
                lvl_ff <= 2'h0;
                cnt_ff <= 11'h000;
                due_ff <= 1'b0;
            end else if (mc_clear) begin
                v_ff <= 1'b0;
                due_ff <= 1'b0;
            end else begin
                if (est_take && free_idx == 3'(i)) begin
                    v_ff <= 1'b1;
                    addr_ff <= est_addr;
                    ivl_ff <= `SMTS_POLL_IVL_RST;
                    lvl_ff <= 2'h0;
                end else if (poll_take && hit_idx == 3'(i)) begin
                    ivl_ff <= parm_ff[15:8];
                end else if (mine && evt_kind == `SMTS_CNT_SEL_TMO
                             && lvl_ff != `SMTS_POLL_LVL_MAX) begin
                    lvl_ff <= lvl_ff + 2'h1;
                end else if (mine && evt_kind == `SMTS_CNT_MSG_RX) begin
                    lvl_ff <= 2'h0;
                end
                if (expire) begin
                    cnt_ff <= reload;
                end else if (tick_ff && cnt_ff != 11'h000) begin
                    cnt_ff <= cnt_ff - 11'h001;
                end
                due_ff <= expire || (due_ff && !served);
            end
        end
    end

    // lowest due slot wins; one poll every other cycle at most
    wire poll_go = due_v != 8'h00 && !pstb_ff && poll_run;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pstb_ff <= 1'b0;
            pslot_ff <= 3'h0;
        end else begin
            pstb_ff <= poll_go;
            if (poll_go) begin
                pslot_ff <= smts_pkg::smts_first_one(due_v);
            end
        end
    end

    assign input_grant_flag = grant_ff;
    assign cmd_done = done_ff;
    assign cmd_error = err_ff;
    assign full_duplex = dup_ff;
    assign station_role = role_ff;
    assign role_locked = lock_ff;
    assign slot_valid = slot_v;
    assign poll_strobe = pstb_ff;
    assign poll_slot = pslot_ff;
endmodule : smts_top

// ---- tb/smts_top_sva.sv ----
// checker of the command handshake and mode results
`timescale 1ns/1ns
`include "smts_params.svh"
module smts_chk (
    input wire logic clk, // controller clock
    input wire logic arst_n, // async reset
    input wire logic master_clear, // clear pulse
    input wire logic run_ind, // running
    input wire logic input_request, // host request
    input wire logic grant_release, // host release
    input wire logic [7:0] command_select_byte, // command type
    input wire logic [15:0] command_parameter_word, // parameter word
    input wire logic [2:0] mode_switch, // switches
    input wire logic mode_switch_en, // switch source
    input wire logic input_grant_flag, // grant
    input wire logic cmd_done, // accepted
    input wire logic cmd_error, // refused
    input wire logic full_duplex, // duplex
    input wire logic [1:0] station_role, // role
    input wire logic role_locked, // lock
    input wire logic [7:0] slot_valid // slots
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_grant;
        $rose(input_grant_flag) |-> $past(input_request) && $past(run_ind);
    endproperty
    a_grant: assert property (p_grant) else $error("grant without request");
    property p_answer;
        input_grant_flag && grant_release && !master_clear
            |=> !input_grant_flag ##1 ((cmd_done ^ cmd_error) || $past(master_clear));
    endproperty
    a_answer: assert property (p_answer) else $error("no answer to command");
    property p_pulse;
        cmd_done |=> !cmd_done;
    endproperty
    a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
    property p_mode;
        cmd_done && $past(command_select_byte[2:0], 2) == `SMTS_CMD_MODE
            |-> full_duplex == $past(command_parameter_word[0], 2)
                && station_role == $past(command_parameter_word[2:1], 2);
    endproperty
    a_mode: assert property (p_mode) else $error("mode code not applied");
    property p_sel;
        (cmd_done || cmd_error) && !($past(command_select_byte[2:0], 2) inside {3'h1, 3'h2})
            |-> cmd_error;
    endproperty
    a_sel: assert property (p_sel) else $error("unknown command accepted");
    property p_hold;
        role_locked && !master_clear && !mode_switch_en |=> $stable(station_role);
    endproperty
    a_hold: assert property (p_hold) else $error("locked role changed");
    property p_clr_sw;
        master_clear && mode_switch_en
            |=> station_role == $past(mode_switch[2:1]) && full_duplex == $past(mode_switch[0]);
    endproperty
    a_clr_sw: assert property (p_clr_sw) else $error("switch role lost at clear");
    property p_estab;
        cmd_done && $past(command_select_byte[2:0], 2) == `SMTS_CMD_CONTROL
            && $past(command_parameter_word[7:0], 2) == 8'h01 |-> slot_valid != 8'h00;
    endproperty
    a_estab: assert property (p_estab) else $error("establish made no slot");
    property p_err_keep;
        cmd_error && !$past(master_clear) |-> slot_valid == $past(slot_valid);
    endproperty
    a_err_keep: assert property (p_err_keep) else $error("refused command moved slots");
    c_mode: cover property (cmd_done && station_role == 2'h2);
    c_err: cover property (cmd_error);
    c_slot: cover property ($rose(slot_valid[0]));
endmodule : smts_chk

bind smts_top smts_chk u_chk (.clk(clk), .arst_n(arst_n), .master_clear(master_clear),
    .run_ind(run_ind), .input_request(input_request), .grant_release(grant_release),
    .command_select_byte(command_select_byte), .command_parameter_word(command_parameter_word),
    .mode_switch(mode_switch), .mode_switch_en(mode_switch_en),
    .input_grant_flag(input_grant_flag), .cmd_done(cmd_done), .cmd_error(cmd_error),
    .full_duplex(full_duplex), .station_role(station_role), .role_locked(role_locked),
    .slot_valid(slot_valid));

// ---- tb/smts_host_model.sv ----
// host program model: claims the ports, loads one command, releases
`timescale 1ns/1ns
module smts_host_model (
    input wire logic clk, // controller clock
    input wire logic input_grant_flag, // host owns ports
    output logic input_request, // ask for ports
    output logic grant_release, // give ports back
    output logic [7:0] command_select_byte, // command type
    output logic [15:0] command_parameter_word, // parameter word
    output logic [7:0] tributary_addr_byte // tributary address
);
    initial begin
        input_request = 1'b0;
        grant_release = 1'b0;
        command_select_byte = 8'h00;
        command_parameter_word = 16'h0000;
        tributary_addr_byte = 8'h00;
    end
    task automatic issue(input logic [7:0] sel, input logic [15:0] wd, input logic [7:0] ad);
        int k;
        k = 0;
        @(negedge clk);
        input_request = 1'b1;
        while (input_grant_flag !== 1'b1 && k < 40) begin
            @(negedge clk);
            k++;
        end
        input_request = 1'b0;
        command_select_byte = sel;
        command_parameter_word = wd;
        tributary_addr_byte = ad;
        @(negedge clk);
        grant_release = 1'b1;
        @(negedge clk);
        grant_release = 1'b0;
        // ports no longer owned: show the inverse, not a stale command
        command_select_byte = ~sel;
        command_parameter_word = ~wd;
        tributary_addr_byte = ~ad;
    endtask : issue
endmodule : smts_host_model

// ---- tb/smts_top_tb.sv ----
// self-checking bench of the station mode and tributary setup interpreter
`timescale 1ns/1ns
`include "smts_params.svh"
module smts_top_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic master_clear = 1'b0;
    logic run_ind = 1'b0;
    logic [7:0] initialization_byte = 8'h00;
    logic [2:0] mode_switch = 3'h0;
    logic mode_switch_en = 1'b0;
    logic trib_switch_en = 1'b0;
    logic [7:0] trib_switch_addr = 8'h00;
    logic evt_valid = 1'b0;
    logic [2:0] evt_slot = 3'h0;
    logic [2:0] evt_kind = 3'h0;
    logic [2:0] stat_slot = 3'h0;
    logic [2:0] stat_loc = 3'h0;
    logic input_request, grant_release, input_grant_flag, cmd_done, cmd_error;
    logic full_duplex, role_locked, poll_strobe;
    logic [7:0] command_select_byte, tributary_addr_byte, slot_valid;
    logic [15:0] command_parameter_word, stat_data;
    logic [1:0] station_role;
    logic [2:0] poll_slot;
    logic [3:0] exp_q[$];
    int error_cnt = 0;
    int n_checks = 0;
    int seed = 32'hb074_4bc5;
    always #20 clk = ~clk;
    smts_top #(.POLL_TICK_CYCLES(4)) u_smts_top (.clk(clk), .arst_n(arst_n),
        .master_clear(master_clear), .run_ind(run_ind), .initialization_byte(initialization_byte),
        .input_request(input_request), .grant_release(grant_release),
        .command_select_byte(command_select_byte), .command_parameter_word(command_parameter_word),
        .tributary_addr_byte(tributary_addr_byte), .mode_switch(mode_switch),
        .mode_switch_en(mode_switch_en), .trib_switch_en(trib_switch_en),
        .trib_switch_addr(trib_switch_addr), .evt_valid(evt_valid), .evt_slot(evt_slot),
        .evt_kind(evt_kind), .stat_slot(stat_slot), .stat_loc(stat_loc), .stat_data(stat_data),
        .input_grant_flag(input_grant_flag), .cmd_done(cmd_done), .cmd_error(cmd_error),
        .full_duplex(full_duplex), .station_role(station_role), .role_locked(role_locked),
        .slot_valid(slot_valid), .poll_strobe(poll_strobe), .poll_slot(poll_slot));
    smts_host_model u_host (.clk(clk), .input_grant_flag(input_grant_flag),
        .input_request(input_request), .grant_release(grant_release),
        .command_select_byte(command_select_byte), .command_parameter_word(command_parameter_word),
        .tributary_addr_byte(tributary_addr_byte));
    task automatic give_verdict();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // expectation is {refused, role, duplex} as seen with the answer pulse
    task automatic cmd(input logic [2:0] sel, input logic [15:0] wd, input logic [7:0] ad,
                       input logic [3:0] exp);
        int k;
        exp_q.push_back(exp);
        u_host.issue({5'h00, sel}, wd, ad);
        k = 0;
        while (exp_q.size() != 0 && k < 30) begin
            @(negedge clk);
            k++;
        end
        if (exp_q.size() != 0) begin
            check("answer wait", 16'h0000, 16'h0001);
            give_verdict();
        end
        // covers the slot clearing gap after an establish
        repeat (10) @(negedge clk);
    endtask : cmd
    // looked at mid-cycle, away from the edge that launches the pulse
    always @(negedge clk) begin
        if (cmd_done === 1'b1 || cmd_error === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("spare answer", 16'h0000, 16'h0001);
            end else begin
                check("answer", {12'h000, exp_q.pop_front()},
                      {12'h000, cmd_error, station_role, full_duplex});
            end
        end
    end
    task automatic pulse_clear();
        master_clear = 1'b1;
        @(negedge clk);
        master_clear = 1'b0;
        @(negedge clk);
    endtask : pulse_clear
    initial begin
        logic [15:0] rnd;
        int k;
        rnd = 16'($random(seed));
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        run_ind = 1'b1;
        @(negedge clk);
        cmd(`SMTS_CMD_MODE, {rnd[15:3], 3'h4}, rnd[7:0], 4'b0100);
        cmd(`SMTS_CMD_MODE, 16'h0006, 8'h00, 4'b1100);
        cmd(`SMTS_CMD_MODE, 16'h0005, 8'h00, 4'b0101);
        cmd(3'h3, 16'h0000, 8'h00, 4'b1101);
        rnd = 16'($random(seed)) | 16'h0001;
        cmd(`SMTS_CMD_CONTROL, 16'h0001, rnd[7:0], 4'b0101);
        cmd(`SMTS_CMD_CONTROL, 16'h0001, rnd[7:0], 4'b0101);
        check("slots", 16'h0001, {8'h00, slot_valid});
        cmd(`SMTS_CMD_CONTROL, 16'h0021, rnd[7:0], 4'b1101);
        cmd(`SMTS_CMD_CONTROL, 16'h0003, rnd[7:0], 4'b1101);
        cmd(`SMTS_CMD_CONTROL, 16'h0802, rnd[7:0], 4'b0101);
        k = 0;
        while (poll_strobe !== 1'b1 && k < 300) begin
            @(negedge clk);
            k++;
        end
        check("poll slot", 16'h0000, {15'h0000, k == 300} | {13'h0000, poll_slot});
        for (int i = 0; i < 3; i++) begin
            evt_kind = (i == 2) ? `SMTS_CNT_SEL_TMO : `SMTS_CNT_MSG_TX;
            evt_valid = 1'b1;
            @(negedge clk);
            evt_valid = 1'b0;
            @(negedge clk);
        end
        repeat (2) @(negedge clk);
        check("tx count", 16'h0002, stat_data);
        stat_loc = `SMTS_CNT_SEL_TMO;
        repeat (2) @(negedge clk);
        check("tmo count", 16'h0001, stat_data);
        pulse_clear();
        check("lock", 16'h0000, {15'h0000, role_locked});
        check("slots", 16'h0000, {8'h00, slot_valid});
        cmd(`SMTS_CMD_MODE, 16'h0007, 8'h00, 4'b0111);
        cmd(`SMTS_CMD_CONTROL, 16'h0001, 8'h03, 4'b0111);
        cmd(`SMTS_CMD_CONTROL, 16'h0001, 8'h04, 4'b0111);
        check("slots", 16'h0003, {8'h00, slot_valid});
        evt_slot = 3'h1;
        evt_kind = `SMTS_CNT_MSG_RX;
        stat_slot = 3'h1;
        stat_loc = `SMTS_CNT_MSG_RX;
        evt_valid = 1'b1;
        @(negedge clk);
        evt_valid = 1'b0;
        repeat (3) @(negedge clk);
        check("rx count", 16'h0001, stat_data);
        mode_switch = 3'h2;
        mode_switch_en = 1'b1;
        repeat (3) @(negedge clk);
        check("switch role", 16'h0001, {14'h0000, station_role});
        cmd(`SMTS_CMD_MODE, 16'h0006, 8'h00, 4'b1010);
        initialization_byte = 8'h08;
        cmd(`SMTS_CMD_MODE, 16'h0006, 8'h00, 4'b0110);
        initialization_byte = 8'h00;
        pulse_clear();
        check("clear role", 16'h0001, {14'h0000, station_role});
        cmd(`SMTS_CMD_CONTROL, 16'h0001, 8'h02, 4'b1010);
        cmd(`SMTS_CMD_CONTROL, 16'h0001, 8'h01, 4'b0010);
        trib_switch_en = 1'b1;
        trib_switch_addr = 8'h01;
        cmd(`SMTS_CMD_CONTROL, 16'h0001, 8'h05, 4'b0010);
        check("slots", 16'h0001, {8'h00, slot_valid});
        give_verdict();
    end
endmodule : smts_top_tb
